/* File: emp_adc_model.sv */
// Behavioural model of the sampling converter feeding the metrology block.
`timescale 1ns/1ps
`default_nettype none
`include "emp_defs.svh"
module emp_adc_model (
  input  wire logic            core_clk_i,
  input  wire logic            arst_n_i,
  output logic                 ev_o,
  output emp_pkg::emp_sample_s sample_o
);
  logic [1:0] cnt;
  logic [3:0] phase;

  function automatic logic signed [23:0] tri_wave(input logic [3:0] k);
    return (k < 4'h8) ? 24'(-350 + 100 * int'(k)) : 24'(1150 - 100 * int'(k));
  endfunction

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 2'h0;
      phase <= 4'h0;
      ev_o <= 1'b0;
      sample_o <= '0;
    end else begin
      cnt <= cnt + 2'h1;
      ev_o <= (cnt == 2'h3);
      if (cnt == 2'h3) begin
        sample_o.volt <= tri_wave(phase);
        sample_o.curr <= tri_wave(phase) >>> 1;
        phase <= phase + 4'h1;
      end else begin
        sample_o <= ~sample_o;
      end
    end
  end
endmodule // emp_adc_model
`default_nettype wire

/* File: emp_defs.svh */
// Constants for the energy metrology and pulse generator block.
`ifndef EMP_DEFS_SVH
`define EMP_DEFS_SVH

`define EMP_SAMPLE_W        24
`define EMP_ACC_W           64
`define EMP_CNT_W           16
`define EMP_CYC_W           8
`define EMP_POWER_W         32
`define EMP_ENERGY_W        48
`define EMP_PERIOD_W        24
`define EMP_FRAC_W          8
`define EMP_FRAC_ONE        9'h100
`define EMP_GAIN_W          17
`define EMP_GAIN_ONE        17'h10000
`define EMP_GAIN_SHIFT      16
`define EMP_DC_SHIFT        16
`define EMP_PER_SHIFT       4
`define EMP_SAMPLE_RATE_HZ  8000
`define EMP_FRAME_SECONDS   1
`define EMP_FRAME_SAMPLES   (`EMP_SAMPLE_RATE_HZ * `EMP_FRAME_SECONDS)
`define EMP_KWH_THRESH      48'h1a3185c50000
`define EMP_PULSES_PER_KWH  48'h1900
`define EMP_TICK            (`EMP_KWH_THRESH / `EMP_PULSES_PER_KWH)
`define EMP_PULSE_LEN       8
`define EMP_DELAY_MAX       8
`define EMP_QUARTER_DLY     40

`endif

/* File: emp_metrology.sv */
// Per-sample metrology back end with frequency tracking and energy pulses.
`timescale 1ns/1ps
`default_nettype none
`include "emp_defs.svh"

// Behaviour
// - Voltage, current, active and reactive power sums each use 64-bit accumulators.
// - Sample and cycle counters; after about one second results are latched and flagged.
// - Hand-off happens only on a mains cycle boundary.
// - Crossing instant is linearly interpolated between the two straddling voltage samples.
// - A rate-of-change check rejects sign flips caused by noise spikes.
// - Cycle period passes through a weak low-pass filter before reporting.
// - Each sample event adds last frame's average power to an energy accumulator.
// - Above threshold, emit one pulse, subtract threshold, keep the excess.
// - Threshold is one energy tick; 6400 pulses per kWh for both energies.
// - Active and reactive pulses each drive their own output.
// - Power in 0.001 W units; kWh constant is 0x1A3185C50000 at 8000 events.
// - Integer phase compensation delays the current channel by N whole samples.
// - Fractional compensation uses a two-tap linear interpolator with coefficients computed by coef(), 1/256 sample.
// - Each coefficient set carries a gain that cancels the interpolator gain.
// - Reactive path multiplies current by 90 degree shifted interpolated voltage.
// - Samples are processed at 8000 Hz, one per sample-ready event taken while clk_en_i is high.
// - Only negative-to-positive voltage transitions count as zero crossings.
// - One working accumulator set; hand-off copies its totals into frame_o and clears the working set.
// - A DC estimate per channel is subtracted from every raw sample.
module emp_metrology #(
  parameter int DELAY_MAX     = `EMP_DELAY_MAX,
  parameter int QUARTER_DLY   = `EMP_QUARTER_DLY,
  parameter int PULSE_LEN     = `EMP_PULSE_LEN,
  parameter int FRAME_SAMPLES = `EMP_FRAME_SAMPLES
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          clk_en_i,
  input  wire logic                          sample_ready_event_i,
  input  wire emp_pkg::emp_sample_s          sample_i,
  input  wire logic [$clog2(DELAY_MAX+1)-1:0] phase_int_i,
  input  wire logic [`EMP_FRAC_W-1:0]        phase_frac_i,
  input  wire logic [`EMP_FRAC_W-1:0]        quad_frac_i,
  input  wire logic [`EMP_SAMPLE_W:0]        slew_limit_i,
  input  wire logic [`EMP_POWER_W-1:0]       avg_act_power_i,
  input  wire logic [`EMP_POWER_W-1:0]       avg_react_power_i,
  output logic                               act_pulse_o,
  output logic                               react_pulse_o,
  output logic                               frame_ready_o,
  output emp_pkg::emp_frame_s                frame_o,
  output logic [`EMP_PERIOD_W-1:0]           period_o
);

  localparam int SW = `EMP_SAMPLE_W;
  localparam int DW = $clog2(DELAY_MAX+1);
  localparam int KW = SW + `EMP_DC_SHIFT;
  localparam int FW = `EMP_PERIOD_W + `EMP_PER_SHIFT;

  if (DELAY_MAX < 1 || QUARTER_DLY < 1 || PULSE_LEN < 1 || PULSE_LEN > 255 ||
      FRAME_SAMPLES < 1 || FRAME_SAMPLES >= (1 << `EMP_CNT_W)) begin : g_bad_param
    $error("emp_metrology: unsupported parameter value");
  end

  function automatic emp_pkg::emp_coef_s coef(input logic [`EMP_FRAC_W-1:0] f);
    emp_pkg::emp_coef_s k;
    k.c0   = `EMP_FRAC_ONE - {1'b0, f};
    k.c1   = {1'b0, f};
    k.gain = `EMP_GAIN_W'(`EMP_GAIN_ONE / {8'h00, k.c0 + k.c1});
    return k;
  endfunction

  function automatic logic signed [SW-1:0] interp(input logic signed [SW-1:0] a,
                                                  input logic signed [SW-1:0] b,
                                                  input logic [`EMP_FRAC_W-1:0] f);
    emp_pkg::emp_coef_s k;
    logic signed [63:0] c0s;
    logic signed [63:0] c1s;
    logic signed [63:0] gs;
    logic signed [63:0] acc;
    k   = coef(f);
    c0s = {55'h0, k.c0};
    c1s = {55'h0, k.c1};
    gs  = {47'h0, k.gain};
    acc = 64'(a) * c0s + 64'(b) * c1s;
    acc = (acc * gs) >>> `EMP_GAIN_SHIFT;
    return acc[SW-1:0];
  endfunction

  function automatic logic signed [`EMP_ACC_W-1:0] mul(input logic signed [SW-1:0] a,
                                                       input logic signed [SW-1:0] b);
    return `EMP_ACC_W'(a) * `EMP_ACC_W'(b);
  endfunction

  logic                        ev;
  logic signed [KW-1:0]        dc_v;
  logic signed [KW-1:0]        dc_i;
  logic signed [SW-1:0]        v_now;
  logic signed [SW-1:0]        i_now;
  logic signed [SW-1:0]        v_prev;
  logic signed [SW-1:0]        i_hist [1:DELAY_MAX+1];
  logic signed [SW-1:0]        v_hist [1:QUARTER_DLY+1];
  logic signed [SW-1:0]        i_a;
  logic signed [SW-1:0]        i_comp;
  logic signed [SW-1:0]        v_quad;
  logic signed [SW:0]          slew;
  logic [SW+`EMP_FRAC_W:0]     frac_num;
  logic [SW+`EMP_FRAC_W:0]     frac_q;
  logic [`EMP_FRAC_W-1:0]      t_now;
  logic [`EMP_FRAC_W-1:0]      t_last;
  logic                        zc;
  logic                        have_zc;
  logic [`EMP_CNT_W-1:0]       since_cnt;
  logic [`EMP_PERIOD_W-1:0]    period_raw;
  logic [FW-1:0]               per_f;
  logic [`EMP_PERIOD_W-1:0]    per_val;
  logic signed [`EMP_ACC_W-1:0] w_v_sq;
  logic signed [`EMP_ACC_W-1:0] w_i_sq;
  logic signed [`EMP_ACC_W-1:0] w_act;
  logic signed [`EMP_ACC_W-1:0] w_react;
  logic signed [`EMP_ACC_W-1:0] p_v_sq;
  logic signed [`EMP_ACC_W-1:0] p_i_sq;
  logic signed [`EMP_ACC_W-1:0] p_act;
  logic signed [`EMP_ACC_W-1:0] p_react;
  logic [`EMP_CNT_W-1:0]       sample_cnt;
  logic [`EMP_CYC_W-1:0]       cycle_cnt;
  logic                        handoff;
  logic [`EMP_ENERGY_W-1:0]    energy [2];
  logic [`EMP_ENERGY_W-1:0]    next_energy [2];
  logic [7:0]                  pulse_cnt [2];
  logic [1:0]                  pulse_q;
  logic [1:0]                  tick_hit;

  assign ev = clk_en_i && sample_ready_event_i;

  always_comb begin
    v_now = SW'(sample_i.volt - SW'(dc_v >>> `EMP_DC_SHIFT));
    i_now = SW'(sample_i.curr - SW'(dc_i >>> `EMP_DC_SHIFT));
    if (phase_int_i == '0) begin
      i_a = i_now;
    end else begin
      i_a = i_hist[phase_int_i];
    end
    i_comp = interp(i_a, i_hist[phase_int_i + DW'(1)], phase_frac_i);
    v_quad = interp(v_hist[QUARTER_DLY], v_hist[QUARTER_DLY+1], quad_frac_i);
    p_v_sq  = mul(v_now, v_now);
    p_i_sq  = mul(i_now, i_now);
    p_act   = mul(v_now, i_comp);
    p_react = mul(v_quad, i_comp);
  end

  always_comb begin
    slew = (SW+1)'(v_now) - (SW+1)'(v_prev);
    zc = v_prev[SW-1] && !v_now[SW-1] && ($unsigned(slew) <= slew_limit_i);
    frac_num = (SW+`EMP_FRAC_W+1)'(-(SW+1)'(v_prev)) << `EMP_FRAC_W;
    frac_q   = (slew == '0) ? '0 : frac_num / (SW+`EMP_FRAC_W+1)'($unsigned(slew));
    t_now    = (frac_q > (SW+`EMP_FRAC_W+1)'({`EMP_FRAC_W{1'b1}})) ? '1 : frac_q[`EMP_FRAC_W-1:0];
    period_raw = `EMP_PERIOD_W'({since_cnt, {`EMP_FRAC_W{1'b0}}}) + `EMP_PERIOD_W'(t_now)
               - `EMP_PERIOD_W'(t_last);
    per_val = per_f[FW-1:`EMP_PER_SHIFT];
    handoff = zc && (sample_cnt >= `EMP_CNT_W'(FRAME_SAMPLES - 1));
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dc_v <= '0;
      dc_i <= '0;
    end else if (ev) begin
      dc_v <= dc_v + KW'(v_now);
      dc_i <= dc_i + KW'(i_now);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int k = 1; k <= DELAY_MAX+1; k++) begin
        i_hist[k] <= '0;
      end
      for (int k = 1; k <= QUARTER_DLY+1; k++) begin
        v_hist[k] <= '0;
      end
    end else if (ev) begin
      i_hist[1] <= i_now;
      v_hist[1] <= v_now;
      for (int k = 2; k <= DELAY_MAX+1; k++) begin
        i_hist[k] <= i_hist[k-1];
      end
      for (int k = 2; k <= QUARTER_DLY+1; k++) begin
        v_hist[k] <= v_hist[k-1];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      v_prev    <= '0;
      t_last    <= '0;
      since_cnt <= '0;
      have_zc   <= 1'b0;
    end else if (ev) begin
      v_prev <= v_now;
      if (zc) begin
        t_last    <= t_now;
        since_cnt <= `EMP_CNT_W'(1);
        have_zc   <= 1'b1;
      end else if (since_cnt != '1) begin
        since_cnt <= since_cnt + `EMP_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      per_f    <= '0;
      period_o <= '0;
    end else if (ev && zc && have_zc) begin
      if (per_f == '0) begin
        per_f    <= FW'(period_raw) << `EMP_PER_SHIFT;
        period_o <= period_raw;
      end else begin
        per_f    <= per_f + FW'(period_raw) - FW'(per_val);
        period_o <= `EMP_PERIOD_W'((per_f + FW'(period_raw) - FW'(per_val)) >> `EMP_PER_SHIFT);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_v_sq     <= '0;
      w_i_sq     <= '0;
      w_act      <= '0;
      w_react    <= '0;
      sample_cnt <= '0;
      cycle_cnt  <= '0;
    end else if (ev) begin
      if (handoff) begin
        w_v_sq     <= '0;
        w_i_sq     <= '0;
        w_act      <= '0;
        w_react    <= '0;
        sample_cnt <= '0;
        cycle_cnt  <= '0;
      end else begin
        w_v_sq     <= w_v_sq + p_v_sq;
        w_i_sq     <= w_i_sq + p_i_sq;
        w_act      <= w_act + p_act;
        w_react    <= w_react + p_react;
        if (sample_cnt != '1) begin
          sample_cnt <= sample_cnt + `EMP_CNT_W'(1);
        end
        if (zc && cycle_cnt != '1) begin
          cycle_cnt <= cycle_cnt + `EMP_CYC_W'(1);
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_o       <= '0;
      frame_ready_o <= 1'b0;
    end else if (clk_en_i) begin
      frame_ready_o <= 1'b0;
      if (ev && handoff) begin
        frame_o.v_sq    <= w_v_sq + p_v_sq;
        frame_o.i_sq    <= w_i_sq + p_i_sq;
        frame_o.act     <= w_act + p_act;
        frame_o.react   <= w_react + p_react;
        frame_o.samples <= sample_cnt + `EMP_CNT_W'(1);
        frame_o.cycles  <= cycle_cnt + `EMP_CYC_W'(1);
        frame_ready_o   <= 1'b1;
      end
    end
  end

  always_comb begin
    next_energy[0] = energy[0] + `EMP_ENERGY_W'(avg_act_power_i);
    next_energy[1] = energy[1] + `EMP_ENERGY_W'(avg_react_power_i);
    for (int c = 0; c < 2; c++) begin
      tick_hit[c] = next_energy[c] >= `EMP_ENERGY_W'(`EMP_TICK);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      energy[0]    <= '0;
      energy[1]    <= '0;
      pulse_cnt[0] <= '0;
      pulse_cnt[1] <= '0;
      pulse_q      <= '0;
    end else if (ev) begin
      for (int c = 0; c < 2; c++) begin
        if (tick_hit[c]) begin
          energy[c]    <= next_energy[c] - `EMP_ENERGY_W'(`EMP_TICK);
          pulse_cnt[c] <= 8'(PULSE_LEN - 1);
          pulse_q[c]   <= 1'b1;
        end else begin
          energy[c] <= next_energy[c];
          if (pulse_cnt[c] != '0) begin
            pulse_cnt[c] <= pulse_cnt[c] - 8'h01;
          end else begin
            pulse_q[c] <= 1'b0;
          end
        end
      end
    end
  end

  assign act_pulse_o   = pulse_q[0];
  assign react_pulse_o = pulse_q[1];

endmodule // emp_metrology
`default_nettype wire

/* File: emp_metrology_checker.sv */
// Port-level assertions for the metrology block.
`timescale 1ns/1ps
`default_nettype none
`include "emp_defs.svh"
module emp_metrology_checker #(
  parameter int FRAME_SAMPLES = `EMP_FRAME_SAMPLES
) (
  input wire logic                     core_clk_i,
  input wire logic                     arst_n_i,
  input wire logic                     clk_en_i,
  input wire logic                     sample_ready_event_i,
  input wire logic                     act_pulse_o,
  input wire logic                     react_pulse_o,
  input wire logic                     frame_ready_o,
  input wire emp_pkg::emp_frame_s      frame_o,
  input wire logic [`EMP_PERIOD_W-1:0] period_o
);
  logic took;
  assign took = sample_ready_event_i & clk_en_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_rst_idle;
    $rose(arst_n_i) |-> !act_pulse_o && !react_pulse_o && !frame_ready_o && period_o == '0;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
  property p_ready_cause;
    frame_ready_o |-> $past(took) || ($past(frame_ready_o) && !$past(clk_en_i));
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("frame flag without event");
  property p_ready_bound;
    frame_ready_o |-> frame_o.cycles != '0 && frame_o.samples >= FRAME_SAMPLES;
  endproperty
  a_ready_bound: assert property (p_ready_bound) else $error("frame handed off early");
  property p_frame_hold;
    $changed(frame_o) |-> frame_ready_o;
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame changed without flag");
  property p_act_cause;
    $changed(act_pulse_o) |-> $past(took);
  endproperty
  a_act_cause: assert property (p_act_cause) else $error("active pulse moved off event");
  property p_react_cause;
    $changed(react_pulse_o) |-> $past(took);
  endproperty
  a_react_cause: assert property (p_react_cause) else $error("reactive pulse moved off event");
  property p_period_cause;
    $changed(period_o) |-> $past(took);
  endproperty
  a_period_cause: assert property (p_period_cause) else $error("period moved off event");
  property p_frozen;
    !clk_en_i |=> $stable({act_pulse_o, react_pulse_o, frame_ready_o, period_o});
  endproperty
  a_frozen: assert property (p_frozen) else $error("outputs moved while disabled");

  c_frame: cover property (frame_ready_o);
  c_act: cover property ($rose(act_pulse_o));
  c_period: cover property ($changed(period_o));
endmodule // emp_metrology_checker

bind emp_metrology emp_metrology_checker #(.FRAME_SAMPLES(FRAME_SAMPLES)) chk_u (
  .core_clk_i,
  .arst_n_i,
  .clk_en_i,
  .sample_ready_event_i,
  .act_pulse_o,
  .react_pulse_o,
  .frame_ready_o,
  .frame_o,
  .period_o
);
`default_nettype wire

/* File: emp_metrology_tb.sv */
// Self-checking testbench for the metrology block.
`timescale 1ns/1ps
`default_nettype none
`include "emp_defs.svh"
module emp_metrology_tb;
  logic                     core_clk_i;
  logic                     arst_n_i;
  logic                     clk_en_i;
  logic                     ev;
  emp_pkg::emp_sample_s     smp;
  logic [`EMP_SAMPLE_W:0]   slew;
  logic [`EMP_POWER_W-1:0]  act_pwr;
  logic [`EMP_POWER_W-1:0]  react_pwr;
  logic                     act_pulse;
  logic                     react_pulse;
  logic                     frame_ready;
  emp_pkg::emp_frame_s      frame;
  logic [`EMP_PERIOD_W-1:0] period;
  logic [3:0]               ph_int;
  logic [7:0]               quad_frac;
  int                       miscompares;
  int                       checks;

  emp_adc_model adc_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .ev_o(ev), .sample_o(smp));

  emp_metrology #(.PULSE_LEN(1), .FRAME_SAMPLES(20)) dut_u (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i),
    .sample_ready_event_i(ev),
    .sample_i(smp),
    .phase_int_i(ph_int),
    .phase_frac_i(8'h00),
    .quad_frac_i(quad_frac),
    .slew_limit_i(slew),
    .avg_act_power_i(act_pwr),
    .avg_react_power_i(react_pwr),
    .act_pulse_o(act_pulse),
    .react_pulse_o(react_pulse),
    .frame_ready_o(frame_ready),
    .frame_o(frame),
    .period_o(period)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task chk(input string name, input logic [63:0] exp_v, input logic [63:0] got);
    checks++;
    if (got !== exp_v) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp_v, got);
    end
  endtask

  task end_sim;
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task do_reset(input logic [24:0] lim);
    @(posedge core_clk_i);
    arst_n_i <= 1'b0;
    slew <= lim;
    repeat (10) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
  endtask

  task ev_wait(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      while (ev !== 1'b1) @(posedge core_clk_i);
    end
    #1;
  endtask

  task t_freq;
    do_reset(25'h000063);
    ev_wait(64);
    chk("period_rej", 24'h0, period);
    chk("samples_rej", 16'h0, frame.samples);
    do_reset(25'h0000c8);
    ev_wait(21);
    chk("ready1", 1'b1, frame_ready);
    chk("samples1", 16'h0015, frame.samples);
    chk("cycles1", 8'h02, frame.cycles);
    chk("period1", 24'h001000, period);
    chk("v_sq1", 64'h0000000000100efb, frame.v_sq);
    chk("i_sq1", 64'h00000000000403ae, frame.i_sq);
    chk("act1", 64'h000000000008076a, frame.act);
    @(posedge core_clk_i);
    ph_int <= 4'h1;
    quad_frac <= 8'h80;
    ev_wait(32);
    chk("samples2", 16'h0020, frame.samples);
    chk("cycles2", 8'h02, frame.cycles);
    chk("period2", 24'h001000, period);
    chk("act2", 64'h00000000000bc5ea, frame.act);
    chk("react2", 64'hfffffffffffb2ab2, frame.react);
    @(posedge core_clk_i);
    arst_n_i <= 1'b0;
    #1;
    chk("rst_period", 24'h0, period);
    chk("rst_samples", 16'h0, frame.samples);
  endtask

  task t_pulse;
    do_reset(25'h0000c8);
    @(posedge core_clk_i);
    act_pwr <= 32'h80000000;
    react_pwr <= 32'h430e2340;
    for (int e = 1; e <= 8; e++) begin
      ev_wait(1);
      chk("act", (e == 3 || e == 5 || e == 7), act_pulse);
      chk("react", (e % 4 == 0), react_pulse);
    end
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    #1;
    chk("frozen_act", 1'b0, act_pulse);
    chk("frozen_react", 1'b1, react_pulse);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    ev_wait(4);
    chk("react12", 1'b1, react_pulse);
    @(posedge core_clk_i);
    arst_n_i <= 1'b0;
    act_pwr <= '0;
    react_pwr <= '0;
    #1;
    chk("rst_react", 1'b0, react_pulse);
  endtask

  initial begin
    #200000;
    miscompares++;
    end_sim;
  end

  initial begin
    arst_n_i = 1'b0;
    clk_en_i = 1'b1;
    slew = 25'h0000c8;
    ph_int = 4'h0;
    quad_frac = 8'h00;
    act_pwr = '0;
    react_pwr = '0;
    miscompares = 0;
    checks = 0;
    t_freq;
    t_pulse;
    end_sim;
  end
endmodule // emp_metrology_tb
`default_nettype wire

/* File: emp_pkg.sv */
// Types shared by the energy metrology and pulse generator block.
`default_nettype none
`include "emp_defs.svh"
package emp_pkg;

  typedef struct packed {
    logic signed [`EMP_SAMPLE_W-1:0] volt;
    logic signed [`EMP_SAMPLE_W-1:0] curr;
  } emp_sample_s;

  typedef struct packed {
    logic signed [`EMP_ACC_W-1:0] v_sq;
    logic signed [`EMP_ACC_W-1:0] i_sq;
    logic signed [`EMP_ACC_W-1:0] act;
    logic signed [`EMP_ACC_W-1:0] react;
    logic [`EMP_CNT_W-1:0]        samples;
    logic [`EMP_CYC_W-1:0]        cycles;
  } emp_frame_s;

  typedef struct packed {
    logic [`EMP_FRAC_W:0]   c0;
    logic [`EMP_FRAC_W:0]   c1;
    logic [`EMP_GAIN_W-1:0] gain;
  } emp_coef_s;

endpackage
`default_nettype wire
